// >>> logic/hpd_config_bank.v
// port disable and upstream current configuration bank with apb access
//
// Overview of operation
// R1: self-powered mode: ports set in self-powered disable byte stay disabled.
// R2: bus-powered mode: bus-powered disable byte selects permanently disabled ports.
// R3: bits 5..1 map ports 5..1; bits 7,6 reserved; bit 0 reads zero.
// R4: any port combination may be disabled; report exact count of enabled ports.
// R5: remaining active ports renumbered into a contiguous logical sequence.
// R6: self-powered current report is self byte times 2 mA.
// R7: bus-powered current report is bus byte times 2 mA.
// R8: programmer includes embedded peripheral current when it reports zero.
// R9: programmer keeps self-powered current at or below 100 mA.
// R10: reset values: self max-power one, others zero, all ports available.
// R11: power mode selects active set before answering enumeration.
`include "hpd_regs.vh"
module hpd_config_bank #(
   parameter NPORTS = `HPD_NPORTS
) (
   input  wire                clk_sys,
   input  wire                rst,
   input  wire                psel,
   input  wire                penable,
   input  wire                pwrite,
   input  wire [11:0]         paddr,
   input  wire [31:0]         pwdata,
   output reg                 pready,
   output reg  [31:0]         prdata,
   output reg                 pslverr,
   input  wire                self_powered_pin,
   output reg  [NPORTS-1:0]   port_enable,
   output reg  [3:0]          enabled_port_count,
   output reg  [NPORTS*3-1:0] logical_port_map,
   output reg  [8:0]          max_current_ma,
   output reg                 self_powered_mode
);
   reg  [7:0]          self_powered_disable_mask_q;
   reg  [7:0]          bus_powered_disable_mask_q;
   reg  [7:0]          self_powered_current_report_q;
   reg  [7:0]          bus_powered_current_report_q;
   reg                 mode_meta_q;
   reg                 mode_sync_q;
   reg                 req_seen_q;
   wire [7:0]          active_mask;
   wire [7:0]          active_current;
   wire [NPORTS-1:0]   avail;
   wire [3:0]          count;
   wire [NPORTS*3-1:0] remap;
   wire [9:0]          idx;
   wire                setup;
   wire                hit;

   function is_mapped;
      input [9:0] a;
      begin
         is_mapped = (a == {2'h0, `HPD_IDX_DIS_SELF})  || (a == {2'h0, `HPD_IDX_DIS_BUS}) ||
                     (a == {2'h0, `HPD_IDX_MAXP_SELF}) || (a == {2'h0, `HPD_IDX_MAXP_BUS}) ||
                     (a == {2'h0, `HPD_IDX_STATUS})    || (a == {2'h0, `HPD_IDX_MAP});
      end
   endfunction

   assign idx   = paddr[11:`HPD_ADDR_LSB];
   assign setup = psel & ~penable;
   assign hit   = is_mapped(idx);

   // power mode pin is asynchronous: two flops first
   always @(posedge clk_sys) begin
      if (rst) begin
         mode_meta_q <= 1'b0;
         mode_sync_q <= 1'b0;
      end else begin
         mode_meta_q <= self_powered_pin;
         mode_sync_q <= mode_meta_q;
      end
   end

   // mode picks the active disable and current set
   assign active_mask    = mode_sync_q ? self_powered_disable_mask_q   // see R1 see R11
                                       : bus_powered_disable_mask_q;   // see R2
   assign active_current = mode_sync_q ? self_powered_current_report_q // see R6
                                       : bus_powered_current_report_q; // see R7
   assign avail = ~active_mask[`HPD_PORT_MSB:`HPD_PORT_LSB];           // see R3

   hpd_port_count #(
      .NPORTS (NPORTS)
   ) u_count (
      .avail (avail),
      .count (count)
   );

   hpd_port_remap #(
      .NPORTS (NPORTS)
   ) u_remap (
      .avail           (avail),
      .phys_of_logical (remap)
   );

   // registered outputs toward the hub core
   always @(posedge clk_sys) begin
      if (rst) begin
         port_enable        <= {NPORTS{1'b0}};
         enabled_port_count <= 4'h0;
         logical_port_map   <= {(NPORTS*3){1'b0}};
         max_current_ma     <= 9'h000;
         self_powered_mode  <= 1'b0;
      end else begin
         port_enable        <= avail;                              // see R1 see R2
         enabled_port_count <= count;                              // see R4
         logical_port_map   <= remap;                              // see R5
         max_current_ma     <= {active_current, 1'b0};             // see R6 see R7
         self_powered_mode  <= mode_sync_q;                        // see R11
      end
   end

   // apb slave: one wait state, answer in second access cycle
   always @(posedge clk_sys) begin
      if (rst) begin
         self_powered_disable_mask_q   <= `HPD_RST_DIS_SELF;       // see R10
         bus_powered_disable_mask_q    <= `HPD_RST_DIS_BUS;        // see R10
         self_powered_current_report_q <= `HPD_RST_MAXP_SELF;      // see R10
         bus_powered_current_report_q  <= `HPD_RST_MAXP_BUS;       // see R10
         pready                        <= 1'b0;
         prdata                        <= 32'h0000_0000;
         pslverr                       <= 1'b0;
         req_seen_q                    <= 1'b0;
      end else begin
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         req_seen_q <= setup;
         if (psel && penable && req_seen_q) begin
            pready  <= 1'b1;
            pslverr <= ~hit;
            prdata  <= 32'h0000_0000;
            if (pwrite) begin
               case (idx)
                  {2'h0, `HPD_IDX_DIS_SELF}: begin
                     self_powered_disable_mask_q <= pwdata[7:0] & `HPD_PORT_MASK; // see R3
                  end
                  {2'h0, `HPD_IDX_DIS_BUS}: begin
                     bus_powered_disable_mask_q <= pwdata[7:0] & `HPD_PORT_MASK;  // see R3
                  end
                  {2'h0, `HPD_IDX_MAXP_SELF}: begin
                     self_powered_current_report_q <= pwdata[7:0];
                  end
                  {2'h0, `HPD_IDX_MAXP_BUS}: begin
                     bus_powered_current_report_q <= pwdata[7:0];
                  end
                  default: begin
                  end
               endcase
            end else begin
               case (idx)
                  {2'h0, `HPD_IDX_DIS_SELF}: begin
                     prdata <= {24'h00_0000, self_powered_disable_mask_q};
                  end
                  {2'h0, `HPD_IDX_DIS_BUS}: begin
                     prdata <= {24'h00_0000, bus_powered_disable_mask_q};
                  end
                  {2'h0, `HPD_IDX_MAXP_SELF}: begin
                     prdata <= {24'h00_0000, self_powered_current_report_q};
                  end
                  {2'h0, `HPD_IDX_MAXP_BUS}: begin
                     prdata <= {24'h00_0000, bus_powered_current_report_q};
                  end
                  {2'h0, `HPD_IDX_STATUS}: begin
                     prdata <= {15'h0000, max_current_ma, 3'h0, self_powered_mode,
                                enabled_port_count};
                  end
                  {2'h0, `HPD_IDX_MAP}: begin
                     prdata <= {11'h000, port_enable, 1'b0, logical_port_map};
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end
endmodule // hpd_config_bank

// >>> logic/hpd_port_count.v
// counts enabled ports in a five-port availability vector
module hpd_port_count #(
   parameter NPORTS = 5
) (
   input  wire [NPORTS-1:0] avail,
   output reg  [3:0]        count
);
   integer i;
   always @* begin
      count = 4'h0;
      for (i = 0; i < NPORTS; i = i + 1) begin
         count = count + {3'h0, avail[i]};
      end
   end
endmodule // hpd_port_count

// >>> logic/hpd_port_remap.v
// compacts enabled physical ports into contiguous logical numbers
module hpd_port_remap #(
   parameter NPORTS = 5
) (
   input  wire [NPORTS-1:0]   avail,
   output reg  [NPORTS*3-1:0] phys_of_logical
);
   integer i;
   reg     [2:0] slot;
   always @* begin
      slot            = 3'h0;
      phys_of_logical = {(NPORTS*3){1'b0}};
      for (i = 0; i < NPORTS; i = i + 1) begin
         if (avail[i]) begin
            phys_of_logical[slot*3 +: 3] = i[2:0] + 3'h1;
            slot = slot + 3'h1;
         end
      end
   end
endmodule // hpd_port_remap

// >>> pkg/hpd_regs.vh
// register map and field constants for the port disable and power config bank
`ifndef HPD_REGS_VH
`define HPD_REGS_VH
`define HPD_IDX_DIS_SELF     8'h2a
`define HPD_IDX_DIS_BUS      8'h2b
`define HPD_IDX_MAXP_SELF    8'h2c
`define HPD_IDX_MAXP_BUS     8'h2d
`define HPD_IDX_STATUS       8'h30
`define HPD_IDX_MAP          8'h31
`define HPD_RST_DIS_SELF     8'h00
`define HPD_RST_DIS_BUS      8'h00
`define HPD_RST_MAXP_SELF    8'h01
`define HPD_RST_MAXP_BUS     8'h00
`define HPD_PORT_MASK        8'h3e
`define HPD_PORT_LSB         1
`define HPD_PORT_MSB         5
`define HPD_NPORTS           5
`define HPD_MA_PER_UNIT      2
`define HPD_ADDR_LSB         2
`endif

// >>> tb/hpd_config_bank_bench.sv
// bench for the port disable and power config bank
module hpd_config_bank_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        want_self = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, mode, err, pin, over;
   logic [4:0]  pen, e;
   logic [3:0]  cnt;
   logic [14:0] map, m_exp;
   logic [8:0]  ma;
   logic [7:0]  masks [4] = '{8'hff, 8'h15, 8'h2a, 8'h00};
   int          n_errors = 0;
   int          compares = 0;
   int          n;
   hpd_config_bank dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .self_powered_pin(pin), .port_enable(pen),
      .enabled_port_count(cnt), .logical_port_map(map), .max_current_ma(ma),
      .self_powered_mode(mode));
   hpd_host_model host_u (.clk_sys(clk_sys), .want_self(want_self), .max_current_ma(ma),
      .self_powered_pin(pin), .over_budget(over));
   initial forever #2.5 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         i++;
      end while (pready !== 1'b1 && i < 16);
      if (i >= 16) begin
         n_errors++;
         test_done();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(rd, x);
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rchk(12'ha8, 32'h0);
      rchk(12'hac, 32'h0);
      rchk(12'hb0, 32'h1);
      rchk(12'hb4, 32'h0);
      chk(ma, 9'h0);
      $display("reset test done");
      foreach (masks[j]) begin
         apb(1'b1, 12'hac, masks[j]);
         rchk(12'hac, masks[j] & 8'h3e);
         e = ~masks[j][5:1];
         m_exp = 15'h0;
         n = 0;
         for (int p = 0; p < 5; p++) begin
            if (e[p]) begin
               m_exp[3*n +: 3] = 3'(p + 1);
               n++;
            end
         end
         chk(pen, e);
         chk(cnt, n);
         chk(map, m_exp);
      end
      $display("bus mask test done");
      want_self <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk(mode, 1'b1);
      apb(1'b1, 12'ha8, 32'h0b);
      apb(1'b1, 12'hb0, 32'h32);
      rchk(12'hb0, 32'h32);
      chk(pen, 5'h1a);
      chk(ma, 9'd100);
      chk(over, 1'b0);
      want_self <= 1'b0;
      apb(1'b1, 12'hb4, 32'h7f);
      repeat (6) @(posedge clk_sys);
      chk(pen, 5'h1f);
      rchk(12'hc0, 32'hfe05);
      apb(1'b0, 12'hfc, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      $display("power mode test done");
      test_done();
   end
endmodule // hpd_config_bank_bench

// >>> tb/hpd_config_bank_props.sv
// assertions on the config bank ports
module hpd_config_bank_props (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic [4:0]  port_enable,
   input wire logic [3:0]  enabled_port_count,
   input wire logic [14:0] logical_port_map,
   input wire logic [8:0]  max_current_ma,
   input wire logic        self_powered_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire wr_done = pready && pwrite && !pslverr;
   a_ready_late: assert property (psel && $rose(penable) |=> pready)
      else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready too long");
   a_err_empty: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad error answer");
   a_count_exact: assert property (enabled_port_count == $countones(port_enable))
      else $error("wrong port count");
   a_first_port: assert property (port_enable != 5'h0 |-> logical_port_map[2:0] != 3'h0)
      else $error("logical port one empty");
   a_current_unit: assert property (max_current_ma[0] == 1'b0)
      else $error("current not in 2 mA steps");
   a_self_mask: assert property (wr_done && paddr == 12'ha8 |-> ##2
      (!self_powered_mode || port_enable == ~$past(pwdata[5:1], 2)))
      else $error("self mask not applied");
   a_bus_current: assert property (wr_done && paddr == 12'hb4 |-> ##2
      (self_powered_mode || max_current_ma == {$past(pwdata[7:0], 2), 1'b0}))
      else $error("bus current wrong");
   a_reset_state: assert property ($fell(rst) |=> port_enable == 5'h1f)
      else $error("ports not all available");
endmodule // hpd_config_bank_props
bind hpd_config_bank hpd_config_bank_props props_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .port_enable(port_enable),
   .enabled_port_count(enabled_port_count), .logical_port_map(logical_port_map),
   .max_current_ma(max_current_ma), .self_powered_mode(self_powered_mode));

// >>> tb/hpd_host_model.sv
// upstream host and supply model
module hpd_host_model (
   input  wire logic       clk_sys,
   input  wire logic       want_self,
   input  wire logic [8:0] max_current_ma,
   output logic            self_powered_pin,
   output logic            over_budget
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge clk_sys) self_powered_pin <= want_self;
   // host budget flag; the programmed bytes already carry embedded peripheral current
   assign over_budget = want_self && max_current_ma > 9'd100;
endmodule // hpd_host_model
